// [logic/hdc_pkg.sv]
// Package for the holdover DAC control block: register map, fields, resets, timing.
// Assumes a 100 MHz pclk and APB with 32-bit data; register indices times four give byte addresses.
package hdc_pkg;

  localparam int unsigned CLK_KHZ = 100000;

  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_HOLDOVER_CONTROL = 12'h014b;
  localparam logic [11:0] IDX_MANUAL_DAC_LOW   = 12'h014c;
  localparam logic [11:0] IDX_LOWER_TRIP       = 12'h014d;
  localparam logic [11:0] IDX_TRIGGER_CONTROL  = 12'h0160;
  localparam logic [11:0] IDX_STATUS           = 12'h0161;
  localparam logic [11:0] IDX_TRACKED_CODE     = 12'h0162;

  // Holdover control fields
  localparam int unsigned CTL_TIMEOUT_LSB = 6;
  localparam int unsigned CTL_CHECK_EN    = 5;
  localparam int unsigned CTL_FOLLOW_EN   = 4;
  localparam int unsigned CTL_FORCE       = 3;
  localparam int unsigned CTL_FIXED_SEL   = 2;
  localparam logic [7:0]  CTL_RESET       = 8'h16;
  localparam logic [7:0]  DAC_LOW_RESET   = 8'h00;
  localparam logic [7:0]  TRIP_RESET      = 8'h00;

  // Trigger control fields: upper trip in [5:0]
  localparam int unsigned TRG_ABSENCE_EN = 6;
  localparam int unsigned TRG_TUNE_EN    = 7;
  localparam logic [7:0]  TRG_RESET      = 8'h00;

  // Tracked code after reset and trip scaling
  localparam logic [9:0]  TRACK_RESET   = 10'h200;
  localparam int unsigned TRIP_STEP_LOG = 4;
  localparam logic [10:0] CODE_SPAN     = 11'h400;

  // Absence timeouts as printed, in kHz, and their cycle counts (rounded down)
  localparam int unsigned TIMEOUT0_KHZ = 370;
  localparam int unsigned TIMEOUT1_KHZ = 2100;
  localparam int unsigned TIMEOUT2_KHZ = 8800;
  localparam int unsigned TIMEOUT3_KHZ = 22000;
  localparam logic [8:0]  TIMEOUT0_CYC = 9'(CLK_KHZ / TIMEOUT0_KHZ);
  localparam logic [8:0]  TIMEOUT1_CYC = 9'(CLK_KHZ / TIMEOUT1_KHZ);
  localparam logic [8:0]  TIMEOUT2_CYC = 9'(CLK_KHZ / TIMEOUT2_KHZ);
  localparam logic [8:0]  TIMEOUT3_CYC = 9'(CLK_KHZ / TIMEOUT3_KHZ);

endpackage

// [logic/hdc_holdover_dac.sv]
// Holdover DAC control: absence timeout, tune tracking DAC, forced holdover, trip band.
// Assumes APB master on pclk; all other inputs synchronous to pclk.
// Behaviour
// - A reference input idle for the selected timeout raises a clock switch event.
// - The absence timeout check runs only while its enable bit is set.
// - With follow enabled the DAC tracks the tuning voltage only while the first loop is locked.
// - After reset the tracked DAC code starts at 512.
// - Tracking runs in every mode, not only in holdover.
// - The override bit forces holdover regardless of other triggers until cleared.
// - In forced holdover the DAC takes the fixed value when selected, else the tracked value.
// - The fixed select bit picks automatic at 0 and manual at 1, and resets to 1.
// - The fixed value is 10 bits, upper two in the control register, lower eight next.
// - The lower trip field n sets a threshold of (n+1) sixty-fourths of Vcc above ground.
// - The upper trip field n sets a threshold of (n+1) sixty-fourths of Vcc below Vcc.
// - Input absence enters holdover only when the absence holdover enable is set.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module hdc_holdover_dac (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        reference_activity,
  input  wire logic        first_loop_locked,
  input  wire logic [9:0]  tune_code,
  input  wire logic        track_tick,
  output logic      [9:0]  dac_code,
  output logic             holdover_active,
  output logic             input_absence,
  output logic             clock_switch_event
);

  // Scaled trip threshold in code units: (n+1) * 1024/64
  function automatic logic [10:0] trip_code(input logic [5:0] n);
    trip_code = 11'({5'h00, n} + 11'h001) << hdc_pkg::TRIP_STEP_LOG;
  endfunction

  function automatic logic [9:0] word_index(input logic [11:0] addr);
    word_index = addr[11:2];
  endfunction

  logic [7:0]  ctl_q, ctl_d;
  logic [7:0]  dac_low_q, dac_low_d;
  logic [7:0]  trip_low_q, trip_low_d;
  logic [7:0]  trg_q, trg_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;
  logic [8:0]  idle_cnt_q, idle_cnt_d;
  logic        absence_q, absence_d;
  logic        event_q, event_d;
  logic [9:0]  tracked_q, tracked_d;
  logic [9:0]  dac_q, dac_d;
  logic        hold_q, hold_d;

  logic        access, mapped;
  logic [9:0]  widx;
  logic [8:0]  timeout_cyc;
  logic [9:0]  fixed_value;
  logic [10:0] low_code, high_code;
  logic        below_low, above_high, tune_trip;
  logic        following;

  assign access      = psel && penable;
  assign widx        = word_index(paddr);
  assign mapped      = (paddr[1:0] == 2'b00) &&
                       (widx == hdc_pkg::IDX_HOLDOVER_CONTROL[9:0] ||
                        widx == hdc_pkg::IDX_MANUAL_DAC_LOW[9:0]   ||
                        widx == hdc_pkg::IDX_LOWER_TRIP[9:0]       ||
                        widx == hdc_pkg::IDX_TRIGGER_CONTROL[9:0]  ||
                        widx == hdc_pkg::IDX_STATUS[9:0]           ||
                        widx == hdc_pkg::IDX_TRACKED_CODE[9:0]);
  assign fixed_value = {ctl_q[1:0], dac_low_q};

  // Register bus: one wait state, write lands on the completing edge
  always_comb begin
    ctl_d      = ctl_q;
    dac_low_d  = dac_low_q;
    trip_low_d = trip_low_q;
    trg_d      = trg_q;
    prdata_d   = prdata_q;
    pready_d   = access && !pready_q;
    pslverr_d  = access && !pready_q && !mapped;
    if (access && !pready_q) begin
      prdata_d = 32'h0000_0000;
      if (mapped && !pwrite) begin
        unique case (widx)
          hdc_pkg::IDX_HOLDOVER_CONTROL[9:0]: prdata_d = {24'h00_0000, ctl_q};
          hdc_pkg::IDX_MANUAL_DAC_LOW[9:0]:   prdata_d = {24'h00_0000, dac_low_q};
          hdc_pkg::IDX_LOWER_TRIP[9:0]:       prdata_d = {24'h00_0000, 2'b00, trip_low_q[5:0]};
          hdc_pkg::IDX_TRIGGER_CONTROL[9:0]:  prdata_d = {24'h00_0000, trg_q[7:6], 6'h00} |
                                                         {26'h000_0000, trg_q[5:0]};
          hdc_pkg::IDX_STATUS[9:0]:           prdata_d = {20'h0_0000, absence_q, hold_q,
                                                          dac_q};
          default:                            prdata_d = {22'h00_0000, tracked_q};
        endcase
      end
    end
    if (access && pready_q && pwrite && mapped) begin
      if (widx == hdc_pkg::IDX_HOLDOVER_CONTROL[9:0]) begin
        ctl_d = pwdata[7:0];
      end
      if (widx == hdc_pkg::IDX_MANUAL_DAC_LOW[9:0]) begin
        dac_low_d = pwdata[7:0];
      end
      if (widx == hdc_pkg::IDX_LOWER_TRIP[9:0]) begin
        trip_low_d = {2'b00, pwdata[5:0]};
      end
      if (widx == hdc_pkg::IDX_TRIGGER_CONTROL[9:0]) begin
        trg_d = pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q      <= hdc_pkg::CTL_RESET;
      dac_low_q  <= hdc_pkg::DAC_LOW_RESET;
      trip_low_q <= hdc_pkg::TRIP_RESET;
      trg_q      <= hdc_pkg::TRG_RESET;
      prdata_q   <= 32'h0000_0000;
      pready_q   <= 1'b0;
      pslverr_q  <= 1'b0;
    end else begin
      ctl_q      <= ctl_d;
      dac_low_q  <= dac_low_d;
      trip_low_q <= trip_low_d;
      trg_q      <= trg_d;
      prdata_q   <= prdata_d;
      pready_q   <= pready_d;
      pslverr_q  <= pslverr_d;
    end
  end

  // Absence timer; timeouts are rounded down so a slow edge never hides a lost input
  always_comb begin
    unique case (ctl_q[hdc_pkg::CTL_TIMEOUT_LSB +: 2])
      2'd0: timeout_cyc = hdc_pkg::TIMEOUT0_CYC;
      2'd1: timeout_cyc = hdc_pkg::TIMEOUT1_CYC;
      2'd2: timeout_cyc = hdc_pkg::TIMEOUT2_CYC;
      2'd3: timeout_cyc = hdc_pkg::TIMEOUT3_CYC;
    endcase
  end

  always_comb begin
    idle_cnt_d = idle_cnt_q;
    absence_d  = absence_q;
    if (!ctl_q[hdc_pkg::CTL_CHECK_EN] || reference_activity) begin
      idle_cnt_d = 9'h000;
      absence_d  = 1'b0;
    end else if (idle_cnt_q >= timeout_cyc - 9'h001) begin
      absence_d = 1'b1;
    end else begin
      idle_cnt_d = idle_cnt_q + 9'h001;
    end
    event_d = absence_d && !absence_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt_q <= 9'h000;
      absence_q  <= 1'b0;
      event_q    <= 1'b0;
    end else begin
      idle_cnt_q <= idle_cnt_d;
      absence_q  <= absence_d;
      event_q    <= event_d;
    end
  end

  // Tracking runs whatever the mode, so the code doubles as a tune voltage monitor
  // One code per tick; the tick rate is set outside this block
  // Slow steps keep a noisy tune reading from dragging the holdover value
  assign following = ctl_q[hdc_pkg::CTL_FOLLOW_EN] && first_loop_locked && track_tick;

  always_comb begin
    tracked_d = tracked_q;
    if (following) begin
      if (tune_code > tracked_q) begin
        tracked_d = tracked_q + 10'h001;
      end else if (tune_code < tracked_q) begin
        tracked_d = tracked_q - 10'h001;
      end
    end
  end

  // Trip band in code units
  assign low_code   = trip_code(trip_low_q[5:0]);
  assign high_code  = hdc_pkg::CODE_SPAN - trip_code(trg_q[5:0]);
  assign below_low  = {1'b0, tracked_q} <= low_code;
  assign above_high = {1'b0, tracked_q} >= high_code;
  assign tune_trip  = trg_q[hdc_pkg::TRG_TUNE_EN] && (below_low || above_high);

  always_comb begin
    hold_d = ctl_q[hdc_pkg::CTL_FORCE]
           || (trg_q[hdc_pkg::TRG_ABSENCE_EN] && absence_q)
           || tune_trip;
    if (hold_d && ctl_q[hdc_pkg::CTL_FIXED_SEL]) begin
      dac_d = fixed_value;
    end else begin
      dac_d = tracked_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tracked_q <= hdc_pkg::TRACK_RESET;
      dac_q     <= hdc_pkg::TRACK_RESET;
      hold_q    <= 1'b0;
    end else begin
      tracked_q <= tracked_d;
      dac_q     <= dac_d;
      hold_q    <= hold_d;
    end
  end

  assign prdata             = prdata_q;
  assign pready             = pready_q;
  assign pslverr            = pslverr_q;
  assign dac_code           = dac_q;
  assign holdover_active    = hold_q;
  assign input_absence      = absence_q;
  assign clock_switch_event = event_q;

  // Checks; helper flag marks the first cycle after reset release
  logic seen_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= 1'b1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  reset_mid_code_a: assert property (!seen_q |-> tracked_q == 10'h200)
    else $error("tracked code not mid scale after reset");

  timeout_event_a: assert property (
      ctl_q[5] && !reference_activity && ctl_q[7:6] == 2'd3 ##1
      (!reference_activity && ctl_q[5] && ctl_q[7:6] == 2'd3) [*3]
      |=> absence_q)
    else $error("absence not raised after shortest timeout");

  check_off_a: assert property (!ctl_q[5] |=> !absence_q && !event_q)
    else $error("absence raised while check disabled");

  follow_idle_a: assert property (!(ctl_q[4] && first_loop_locked) |=> $stable(tracked_q))
    else $error("tracked code moved without lock and follow");

  follow_step_a: assert property (following && tune_code > tracked_q
      |=> tracked_q == $past(tracked_q) + 10'h001)
    else $error("tracked code missed an upward step");

  force_hold_a: assert property (ctl_q[3] |=> hold_q)
    else $error("forced holdover not active");

  fixed_out_a: assert property (ctl_q[3] && ctl_q[2]
      |=> dac_q == $past({ctl_q[1:0], dac_low_q}))
    else $error("fixed value not driven in forced holdover");

  tracked_out_a: assert property (ctl_q[3] && !ctl_q[2] |=> dac_q == $past(tracked_q))
    else $error("tracked value not driven in forced holdover");

  auto_out_a: assert property (!hold_d |=> dac_q == $past(tracked_q) && !hold_q)
    else $error("dac not tracking outside holdover");

  low_trip_a: assert property (trg_q[7] && {1'b0, tracked_q} <=
      11'({5'h00, trip_low_q[5:0]}) * 11'h010 + 11'h010 |=> hold_q)
    else $error("lower trip did not enter holdover");

  high_trip_a: assert property (trg_q[7] && {1'b0, tracked_q} >=
      11'h400 - 11'({trg_q[5:0], 4'h0}) - 11'h010 |=> hold_q)
    else $error("upper trip did not enter holdover");

  absence_hold_a: assert property (absence_q && !trg_q[6] && !ctl_q[3] && !tune_trip
      |=> !hold_q)
    else $error("absence entered holdover while disabled");

  band_hold_a: assert property (!trg_q[7] && !trg_q[6] && !ctl_q[3] |=> !hold_q)
    else $error("holdover without any trigger");

  // Event is a one-cycle pulse, so nothing has to clear it
  event_rise_a: assert property (event_q |-> absence_q && !$past(absence_q))
    else $error("switch event without a fresh absence");

  event_pulse_a: assert property (event_q |=> !event_q)
    else $error("switch event longer than one cycle");

  absence_clear_a: assert property (reference_activity |=> !absence_q)
    else $error("absence held despite activity");

  check_clear_a: assert property (!ctl_q[5] |=> idle_cnt_q == 9'h000)
    else $error("idle count kept while check disabled");

  follow_down_a: assert property (following && tune_code < tracked_q
      |=> tracked_q == $past(tracked_q) - 10'h001)
    else $error("tracked code missed a downward step");

  track_step_a: assert property (1'b1 |=> tracked_q == $past(tracked_q) ||
      tracked_q == $past(tracked_q) + 10'h001 || tracked_q == $past(tracked_q) - 10'h001)
    else $error("tracked code jumped by more than one");

  reset_fixed_a: assert property (!seen_q |-> ctl_q[2] && !hold_q &&
      dac_q == hdc_pkg::TRACK_RESET)
    else $error("fixed select or dac wrong after reset");

  any_hold_fixed_a: assert property (hold_d && ctl_q[2] |=> dac_q == $past(fixed_value))
    else $error("fixed value not driven in holdover");

  // Bus handshake: exactly one wait state, a master must not assume more
  bus_wait_a: assert property (psel && penable && !pready_q |=> pready_q)
    else $error("bus answer not after one wait state");

  ready_pulse_a: assert property (pready_q |=> !pready_q)
    else $error("ready held longer than one cycle");

  error_ready_a: assert property (pslverr_q |-> pready_q)
    else $error("slave error without ready");

  ro_ignore_a: assert property (access && pready_q && pwrite &&
      widx == hdc_pkg::IDX_TRACKED_CODE[9:0] |=> $stable(ctl_q) && $stable(trg_q))
    else $error("write to read only word changed settings");

  absence_seen_c: cover property (event_q);
  forced_fixed_c: cover property (hold_q && ctl_q[2]);
  tune_trip_c: cover property (tune_trip ##1 hold_q);
  bus_error_c: cover property (pready_q && pslverr_q);
  follow_move_c: cover property (following && tune_code != tracked_q);

endmodule

`default_nettype wire

// [testbench/hdc_holdover_dac_tb.sv]
// Self-checking bench for the holdover DAC control block: APB, tracking, force, trips, absence.
// Assumes the design answers APB with one wait state and is the only bus slave.
`timescale 1ns/1ps
`default_nettype none
module hdc_holdover_dac_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        reference_activity;
  logic        first_loop_locked;
  logic [9:0]  tune_code;
  logic        track_tick;
  logic [9:0]  dac_code;
  logic        holdover_active;
  logic        input_absence;
  logic        clock_switch_event;
  int          miscompares;
  int          checks_done;
  int          events;
  int          seed;
  int          tm;
  logic [9:0]  fix;
  logic [33:0] mon_e;
  logic [33:0] exp_q[$];

  hdc_holdover_dac u_hdc_holdover_dac (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .reference_activity(reference_activity),
    .first_loop_locked(first_loop_locked), .tune_code(tune_code), .track_tick(track_tick),
    .dac_code(dac_code), .holdover_active(holdover_active), .input_absence(input_absence),
    .clock_switch_event(clock_switch_event));

  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Request held from setup until the edge after pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     input logic [31:0] exp, input logic err);
    int n;
    n = 0;
    exp_q.push_back({~w, err, exp});
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      $display("ERROR pready expected 1 seen 0");
    end
    @(posedge pclk);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    apb(1'h1, {idx[9:0], 2'h0}, d, 32'h0000_0000, 1'h0);
  endtask

  task automatic rd(input logic [11:0] idx, input logic [31:0] exp);
    apb(1'h0, {idx[9:0], 2'h0}, 8'h00, exp, 1'h0);
  endtask

  task automatic outs(input logic [9:0] d, input logic h);
    @(negedge pclk);
    chk("dac_code", {22'h00_0000, d}, {22'h00_0000, dac_code});
    chk("holdover_active", {31'h0000_0000, h}, {31'h0000_0000, holdover_active});
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge pclk);
      track_tick <= 1'h1;
      @(posedge pclk);
      track_tick <= 1'h0;
    end
  endtask

  function automatic logic [31:0] st(input logic a, input logic h, input logic [9:0] d);
    return {20'h0_0000, a, h, d};
  endfunction

  // Monitor: settled outputs sampled mid-cycle, oldest note compared
  always @(negedge pclk) begin
    if (clock_switch_event === 1'h1) events++;
    if (pready === 1'h1) begin
      if (exp_q.size() == 0) begin
        miscompares++;
        $display("ERROR bus answer expected none seen 1");
      end
      else begin
        mon_e = exp_q.pop_front();
        chk("pslverr", {31'h0000_0000, mon_e[32]}, {31'h0000_0000, pslverr});
        if (mon_e[33]) chk("prdata", mon_e[31:0], prdata);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    $display("ERROR watchdog expected done seen running");
    print_verdict();
  end

  initial begin
    {psel, penable, pwrite, track_tick, first_loop_locked, reference_activity} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    tune_code = 10'h205;
    presetn = 1'h0;
    seed = 32'h0000_40e2;
    {miscompares, checks_done, events} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    rd(hdc_pkg::IDX_HOLDOVER_CONTROL, 32'h0000_0016);
    rd(hdc_pkg::IDX_MANUAL_DAC_LOW, 32'h0000_0000);
    rd(hdc_pkg::IDX_LOWER_TRIP, 32'h0000_0000);
    rd(hdc_pkg::IDX_TRACKED_CODE, 32'h0000_0200);
    rd(hdc_pkg::IDX_STATUS, st(1'h0, 1'h0, 10'h200));
    apb(1'h0, {hdc_pkg::IDX_LOWER_TRIP[9:0], 2'h1}, 8'h00, 32'h0000_0000, 1'h1);
    apb(1'h1, 12'hffc, 8'h5a, 32'h0000_0000, 1'h1);
    wr(hdc_pkg::IDX_TRACKED_CODE, 8'hff);
    first_loop_locked <= 1'h1;
    tick(3);
    rd(hdc_pkg::IDX_TRACKED_CODE, 32'h0000_0203);
    first_loop_locked <= 1'h0;
    tick(2);
    rd(hdc_pkg::IDX_TRACKED_CODE, 32'h0000_0203);
    first_loop_locked <= 1'h1;
    wr(hdc_pkg::IDX_HOLDOVER_CONTROL, 8'h06);
    tick(2);
    rd(hdc_pkg::IDX_TRACKED_CODE, 32'h0000_0203);
    fix = 10'($random(seed));
    wr(hdc_pkg::IDX_MANUAL_DAC_LOW, fix[7:0]);
    wr(hdc_pkg::IDX_HOLDOVER_CONTROL, {6'h07, fix[9:8]});
    rd(hdc_pkg::IDX_STATUS, st(1'h0, 1'h1, fix));
    outs(fix, 1'h1);
    rd(hdc_pkg::IDX_HOLDOVER_CONTROL, {24'h00_0000, 6'h07, fix[9:8]});
    tick(1);
    rd(hdc_pkg::IDX_TRACKED_CODE, 32'h0000_0204);
    wr(hdc_pkg::IDX_HOLDOVER_CONTROL, {6'h06, fix[9:8]});
    rd(hdc_pkg::IDX_STATUS, st(1'h0, 1'h1, 10'h204));
    outs(10'h204, 1'h1);
    wr(hdc_pkg::IDX_HOLDOVER_CONTROL, 8'h14);
    rd(hdc_pkg::IDX_STATUS, st(1'h0, 1'h0, 10'h204));
    outs(10'h204, 1'h0);
    fix[9:8] = 2'h0;
    // Tracked code 516 against lower 512/528 and upper 512/528
    wr(hdc_pkg::IDX_LOWER_TRIP, 8'd31);
    wr(hdc_pkg::IDX_TRIGGER_CONTROL, 8'h80);
    rd(hdc_pkg::IDX_STATUS, st(1'h0, 1'h0, 10'h204));
    wr(hdc_pkg::IDX_LOWER_TRIP, 8'd32);
    rd(hdc_pkg::IDX_STATUS, st(1'h0, 1'h1, fix));
    wr(hdc_pkg::IDX_TRIGGER_CONTROL, 8'h00);
    rd(hdc_pkg::IDX_STATUS, st(1'h0, 1'h0, 10'h204));
    wr(hdc_pkg::IDX_LOWER_TRIP, 8'h00);
    wr(hdc_pkg::IDX_TRIGGER_CONTROL, 8'h9f);
    rd(hdc_pkg::IDX_STATUS, st(1'h0, 1'h1, fix));
    wr(hdc_pkg::IDX_TRIGGER_CONTROL, 8'h9e);
    rd(hdc_pkg::IDX_STATUS, st(1'h0, 1'h0, 10'h204));
    repeat (300) @(posedge pclk);
    chk("switch events", 32'h0000_0000, events);
    rd(hdc_pkg::IDX_STATUS, st(1'h0, 1'h0, 10'h204));
    reference_activity <= 1'h1;
    for (int t = 0; t < 4; t++) begin
      tm = (t == 0) ? int'(hdc_pkg::TIMEOUT0_CYC) : (t == 1) ? int'(hdc_pkg::TIMEOUT1_CYC) :
           (t == 2) ? int'(hdc_pkg::TIMEOUT2_CYC) : int'(hdc_pkg::TIMEOUT3_CYC);
      wr(hdc_pkg::IDX_TRIGGER_CONTROL, (t >= 2) ? 8'h40 : 8'h00);
      wr(hdc_pkg::IDX_HOLDOVER_CONTROL, {2'(t), 6'h30});
      @(posedge pclk);
      reference_activity <= 1'h0;
      repeat (tm / 2) @(negedge pclk);
      chk("input_absence", 32'h0000_0000, {31'h0000_0000, input_absence});
      repeat (tm / 2 + 4) @(negedge pclk);
      chk("input_absence", 32'h0000_0001, {31'h0000_0000, input_absence});
      chk("switch events", 32'(t + 1), events);
      rd(hdc_pkg::IDX_STATUS, st(1'h1, t >= 2, 10'h204));
      outs(10'h204, t >= 2);
      @(posedge pclk);
      reference_activity <= 1'h1;
      repeat (3) @(negedge pclk);
      chk("input_absence", 32'h0000_0000, {31'h0000_0000, input_absence});
    end
    repeat (5) @(posedge pclk);
    chk("pending reads", 32'h0000_0000, exp_q.size());
    print_verdict();
  end
endmodule
`default_nettype wire
